// file: logic/crei_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CREI_CONSTS_SVH
`define CREI_CONSTS_SVH
`define CREI_OFF_CTRL 12'h000
`define CREI_OFF_IEN 12'h004
`define CREI_OFF_PEND 12'h008
`define CREI_OFF_VEC 12'h00C
`define CREI_OFF_STAT 12'h010
`define CREI_OFF_EXCA 12'h014
`define CREI_CTRL_GIE 0
`define CREI_CTRL_SAVED 1
`define CREI_STAT_IRQ 0
`define CREI_STAT_ST_LO 1
`define CREI_STAT_CAUSE_LO 3
`define CREI_RST_GIE 1'b0
`define CREI_RST_IEN 32'h00000000
`define CREI_VEC_NONE 32'hFFFFFFFF
`define CREI_VEC_SCALE 8
`define CREI_ACK_PERIOD_NS 80
`define CREI_FETCH_PERIOD_NS 40
`define CREI_CLK_NS 5
`define CREI_ACK_CYC (`CREI_ACK_PERIOD_NS / `CREI_CLK_NS)
`define CREI_FETCH_CYC (`CREI_FETCH_PERIOD_NS / `CREI_CLK_NS)
`endif

// file: logic/crei_ctrl.sv
// Reset, exception and interrupt control with an APB register slave
// What this block does
// - The global reset puts the core in reset at once, with no drain.
// - A local reset request drains the pipeline before reset is entered.
// - Reaching local reset pulses the acknowledge for one cycle, repeated.
// - The core stays in reset while the local request is held.
// - In reset the core keeps reading the reset address and drops the data.
// - The request is ignored under debug and honoured after if still held.
// - Every exception cause goes to the one common exception address.
// - The exception address is a build-time parameter, fixed at run time.
// - There are 32 level-sensitive requests, held by sources until served.
// - Software writes a per-source enable register, one bit per request.
// - A hardware interrupt is raised only when global, request and enable agree.
// - No fixed priority between sources; software orders them.
// - Interrupts nest once software sets the global enable again.
// - Without multiply/divide hardware such an instruction traps.
// - Vector read is negative if nothing pends or saved enable is 0, else 8*n.
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
`include "crei_consts.svh"
module crei_ctrl #(
    parameter logic [31:0] EXC_ADDR = 32'h00000020,
    parameter logic [31:0] RESET_ADDR = 32'h00000000,
    parameter bit HAS_MULDIV = 1'b0
) (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Global reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address or on a write to a read-only register
    input wire logic [31:0] irq, // Level interrupt requests
    input wire logic reset_request, // Local reset request
    input wire logic debug_active, // Debug module owns the core
    input wire logic pipe_empty, // No instruction left in flight
    input wire logic instr_boundary, // Instruction boundary this cycle
    input wire logic instr_muldiv, // Issued instruction is mul or div
    input wire logic fetch_ack, // Reset-address read returned
    output logic reset_taken, // Local reset acknowledge pulse
    output logic in_reset, // Core held in local reset
    output logic fetch_req, // Reset-address read request
    output logic [31:0] fetch_addr, // Reset-address read address
    output logic exc_take, // Redirect pulse
    output logic [31:0] exc_target, // Redirect address
    output logic hw_irq // Registered interrupt condition
);
    localparam logic [7:0] ACK_CYC = 8'(`CREI_ACK_CYC);
    localparam logic [7:0] FETCH_CYC = 8'(`CREI_FETCH_CYC);

    crei_pkg::crei_state_e state;
    crei_pkg::crei_cause_e cause;
    logic global_irq_enable;
    logic saved_enable;
    logic [31:0] irq_enable;
    logic [7:0] ack_cnt;
    logic [7:0] fetch_cnt;
    logic fetch_wait;
    logic [31:0] pending;
    logic take_irq;
    logic take_md;
    logic wr_en;
    logic rd_en;
    logic [7:0] since_ack;

    // Lowest set bit picks the slot; no hardware ranking beyond it
    function automatic logic [31:0] vec_of(input logic [31:0] p,
                                           input logic en);
        logic [31:0] v;
        v = `CREI_VEC_NONE;
        if (en) begin
            for (int i = 31; i >= 0; i--) begin
                if (p[i]) begin
                    v = 32'(i * `CREI_VEC_SCALE);
                end
            end
        end
        return v;
    endfunction

    assign pending = irq & irq_enable;
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && penable && !pready;
    // Only a running core at a boundary may be redirected
    assign take_irq = hw_irq && instr_boundary &&
                      state == crei_pkg::ST_RUN;
    assign take_md = !HAS_MULDIV && instr_muldiv && instr_boundary &&
                     state == crei_pkg::ST_RUN;

    // Condition sampled every clock; any enabled source counts alike
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_irq <= 1'b0;
        end else begin
            hw_irq <= global_irq_enable && |pending;
        end
    end

    // Local reset sequencing; the global reset acts at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= crei_pkg::ST_HELD;
        end else begin
            case (state)
                crei_pkg::ST_RUN: begin
                    if (reset_request && !debug_active) begin
                        state <= crei_pkg::ST_DRAIN;
                    end
                end
                crei_pkg::ST_DRAIN: begin
                    if (pipe_empty) begin
                        state <= crei_pkg::ST_HELD;
                    end
                end
                default: begin
                    if (!reset_request) begin
                        state <= crei_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    // Acknowledge on arrival and every ACK_CYC cycles while held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_cnt <= 8'h00;
            reset_taken <= 1'b0;
        end else if (state == crei_pkg::ST_DRAIN && pipe_empty) begin
            ack_cnt <= 8'h00; // Restart so every gap is ACK_CYC cycles
            reset_taken <= 1'b1;
        end else if (state == crei_pkg::ST_HELD && reset_request) begin
            ack_cnt <= (ack_cnt == ACK_CYC - 8'h01) ? 8'h00 : ack_cnt + 8'h01;
            reset_taken <= ack_cnt == ACK_CYC - 8'h01;
        end else begin
            ack_cnt <= 8'h00;
            reset_taken <= 1'b0;
        end
    end

    // Dummy reads of the reset address; returned data is never kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_cnt <= 8'h00;
            fetch_req <= 1'b0;
            fetch_wait <= 1'b0;
        end else if (state != crei_pkg::ST_HELD) begin
            fetch_cnt <= 8'h00;
            fetch_req <= 1'b0;
            fetch_wait <= 1'b0;
        end else if (fetch_wait) begin
            fetch_req <= 1'b0;
            fetch_wait <= !fetch_ack;
        end else if (fetch_cnt == FETCH_CYC - 8'h01) begin
            fetch_cnt <= 8'h00;
            fetch_req <= 1'b1;
            fetch_wait <= 1'b1;
        end else begin
            fetch_cnt <= fetch_cnt + 8'h01;
            fetch_req <= 1'b0;
        end
    end

    // Held-in-reset flag and fixed addresses, all from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_reset <= 1'b1;
            fetch_addr <= 32'h00000000;
            exc_target <= 32'h00000000;
        end else begin
            // Rises with the acknowledge, not while the pipeline drains
            in_reset <= state == crei_pkg::ST_HELD ||
                        (state == crei_pkg::ST_DRAIN && pipe_empty);
            fetch_addr <= RESET_ADDR;
            exc_target <= EXC_ADDR;
        end
    end

    // One common redirect for every cause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_take <= 1'b0;
            cause <= crei_pkg::CAUSE_NONE;
        end else begin
            exc_take <= take_irq || take_md;
            if (take_md) begin
                cause <= crei_pkg::CAUSE_MULDIV;
            end else if (take_irq) begin
                cause <= crei_pkg::CAUSE_IRQ;
            end
        end
    end

    // Global enable saved and dropped on entry; software may set it again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_irq_enable <= `CREI_RST_GIE;
            saved_enable <= 1'b0;
        end else if (take_irq || take_md) begin
            saved_enable <= global_irq_enable;
            global_irq_enable <= 1'b0; // Entry wins over a same-cycle write
        end else if (wr_en && paddr == `CREI_OFF_CTRL) begin
            global_irq_enable <= pwdata[`CREI_CTRL_GIE];
        end
    end

    // Per-source enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= `CREI_RST_IEN;
        end else if (wr_en && paddr == `CREI_OFF_IEN) begin
            irq_enable <= pwdata;
        end
    end

    // APB: one wait state, read data captured with the ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (paddr == `CREI_OFF_CTRL) begin
                prdata[`CREI_CTRL_GIE] <= global_irq_enable;
                prdata[`CREI_CTRL_SAVED] <= saved_enable;
            end else if (paddr == `CREI_OFF_IEN) begin
                prdata <= irq_enable;
            end else if (paddr == `CREI_OFF_PEND) begin
                prdata <= pending;
            end else if (paddr == `CREI_OFF_VEC) begin
                prdata <= vec_of(pending, saved_enable);
            end else if (paddr == `CREI_OFF_STAT) begin
                prdata[`CREI_STAT_IRQ] <= hw_irq;
                prdata[`CREI_STAT_ST_LO +: 2] <= state;
                prdata[`CREI_STAT_CAUSE_LO +: 2] <= cause;
            end else if (paddr == `CREI_OFF_EXCA) begin
                prdata <= EXC_ADDR;
            end else begin
                pslverr <= !pwrite;
            end
            if (pwrite) begin
                prdata <= 32'h00000000;
                pslverr <= paddr != `CREI_OFF_CTRL &&
                           paddr != `CREI_OFF_IEN;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    property p_irq_cond;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> hw_irq == $past(global_irq_enable && |(irq & irq_enable));
    endproperty
    a_irq_cond: assert property (p_irq_cond) else $error("irq cond");

    property p_drain_first;
        @(posedge pclk) disable iff (!presetn)
        state == crei_pkg::ST_DRAIN && !pipe_empty
            |=> state == crei_pkg::ST_DRAIN;
    endproperty
    a_drain_first: assert property (p_drain_first) else $error("drain");

    property p_ack_one;
        @(posedge pclk) disable iff (!presetn)
        reset_taken |=> !reset_taken;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack width");

    // Cycles since the last acknowledge while the request is held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_ack <= 8'h00;
        end else if (reset_taken) begin
            since_ack <= 8'h01;
        end else if (state == crei_pkg::ST_HELD && reset_request) begin
            since_ack <= since_ack + 8'h01;
        end else begin
            since_ack <= 8'h00;
        end
    end

    property p_ack_repeat;
        @(posedge pclk) disable iff (!presetn)
        since_ack != 8'h00 && state == crei_pkg::ST_HELD && reset_request
            |-> reset_taken == (since_ack == ACK_CYC);
    endproperty
    a_ack_repeat: assert property (p_ack_repeat) else $error("ack rep");

    property p_hold;
        @(posedge pclk) disable iff (!presetn)
        state == crei_pkg::ST_HELD && reset_request
            |=> state == crei_pkg::ST_HELD ##1 in_reset;
    endproperty
    a_hold: assert property (p_hold) else $error("left reset");

    property p_fetch;
        @(posedge pclk) disable iff (!presetn)
        state == crei_pkg::ST_HELD && !fetch_wait
            |-> ##[0:8] fetch_req || state != crei_pkg::ST_HELD;
    endproperty
    a_fetch: assert property (p_fetch) else $error("no fetch");

    property p_debug;
        @(posedge pclk) disable iff (!presetn)
        state == crei_pkg::ST_RUN && debug_active |=>
            state == crei_pkg::ST_RUN;
    endproperty
    a_debug: assert property (p_debug) else $error("debug");

    property p_target;
        @(posedge pclk) disable iff (!presetn)
        exc_take |-> exc_target == EXC_ADDR;
    endproperty
    a_target: assert property (p_target) else $error("target");

    property p_muldiv;
        @(posedge pclk) disable iff (!presetn)
        take_md |=> exc_take && cause == crei_pkg::CAUSE_MULDIV
            && !global_irq_enable;
    endproperty
    a_muldiv: assert property (p_muldiv) else $error("muldiv");

    property p_boundary;
        @(posedge pclk) disable iff (!presetn)
        exc_take |-> $past(instr_boundary) &&
            $past(state) == crei_pkg::ST_RUN;
    endproperty
    a_boundary: assert property (p_boundary) else $error("boundary");
endmodule

// file: logic/crei_pkg.sv
// Types shared by the reset, exception and interrupt control block
package crei_pkg;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_DRAIN,
        ST_HELD
    } crei_state_e;
    typedef enum logic [1:0] {
        CAUSE_NONE,
        CAUSE_IRQ,
        CAUSE_MULDIV
    } crei_cause_e;
endpackage

// file: sim/crei_far_model.sv
// Interrupt sources and reset-address memory facing the control block
`timescale 1ns/1ps
module crei_far_model #(
    parameter int ACK_DELAY = 3
) (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Global reset, active low
    input wire logic [31:0] irq_raise, // Sources to assert
    input wire logic [31:0] irq_serve, // Sources serviced by software
    input wire logic fetch_req, // Read of the reset address
    output logic [31:0] irq, // Level requests to the core
    output logic fetch_ack // Read returned
);
    int wait_cnt;
    // A source keeps its level until software services it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 32'h00000000;
        end else begin
            irq <= (irq | irq_raise) & ~irq_serve;
        end
    end
    // Memory answers a few cycles late, so the poll is not instant
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 0;
            fetch_ack <= 1'b0;
        end else begin
            fetch_ack <= (wait_cnt == 1);
            if (fetch_req) begin
                wait_cnt <= ACK_DELAY;
            end else if (wait_cnt != 0) begin
                wait_cnt <= wait_cnt - 1;
            end
        end
    end
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the reset, exception and interrupt control
`timescale 1ns/1ps
`include "crei_consts.svh"
module tb_top;
    localparam logic [31:0] EXC_A = 32'h00000120;
    localparam logic [31:0] RST_A = 32'h00000400;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] raise = 32'h00000000;
    logic [31:0] serve = 32'h00000000;
    logic reset_request = 1'b0;
    logic debug_active = 1'b0;
    logic pipe_empty = 1'b1;
    logic instr_boundary = 1'b0;
    logic instr_muldiv = 1'b0;
    logic pready, pslverr, fetch_ack, fetch_req, reset_taken, in_reset;
    logic exc_take, hw_irq;
    logic [31:0] prdata, irq, fetch_addr, exc_target;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    int fetches = 0;

    always #2.5 pclk = ~pclk;

    crei_ctrl #(.EXC_ADDR(EXC_A), .RESET_ADDR(RST_A), .HAS_MULDIV(1'b0))
    u_crei_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .reset_request(reset_request), .debug_active(debug_active),
        .pipe_empty(pipe_empty), .instr_boundary(instr_boundary),
        .instr_muldiv(instr_muldiv), .fetch_ack(fetch_ack),
        .reset_taken(reset_taken), .in_reset(in_reset),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr),
        .exc_take(exc_take), .exc_target(exc_target), .hw_irq(hw_irq));

    crei_far_model u_crei_far_model (.pclk(pclk), .presetn(presetn),
        .irq_raise(raise), .irq_serve(serve), .fetch_req(fetch_req),
        .irq(irq), .fetch_ack(fetch_ack));

    task automatic report_and_stop;
        if (failures == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; slave latency is not assumed, only bounded
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] er,
                       input logic ee);
        int n;
        logic [31:0] r;
        logic e;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // Ready and data are taken at the very edge that sees ready high
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        check("pready", {31'h00000000, pready}, 32'h00000001);
        psel <= 1'b0;
        penable <= 1'b0;
        check("pslverr", {31'h00000000, e}, {31'h00000000, ee});
        if (!w) begin
            check("prdata", r, er);
        end
    endtask

    // Drive one cycle of source changes through the far-side model
    task automatic src(input logic [31:0] up, input logic [31:0] down);
        @(posedge pclk);
        raise <= up;
        serve <= down;
        @(posedge pclk);
        raise <= 32'h00000000;
        serve <= 32'h00000000;
    endtask

    // One instruction boundary, then look for the redirect pulse
    task automatic take(input logic md, input logic exp);
        @(posedge pclk);
        instr_boundary <= 1'b1;
        instr_muldiv <= md;
        @(posedge pclk);
        instr_boundary <= 1'b0;
        instr_muldiv <= 1'b0;
        @(negedge pclk);
        check("exc_take", {31'h00000000, exc_take}, {31'h00000000, exp});
        if (exp) begin
            check("exc_target", exc_target, EXC_A);
        end
    endtask

    // Reads the named output at the falling edge, where it has settled
    task automatic flag(input string name, input logic exp);
        logic v;
        @(negedge pclk);
        if (name == "hw_irq") begin
            v = hw_irq;
        end else if (name == "in_reset") begin
            v = in_reset;
        end else begin
            v = reset_taken;
        end
        check(name, {31'h00000000, v}, {31'h00000000, exp});
    endtask

    task automatic t_regs;
        acc(1'b0, `CREI_OFF_CTRL, 32'h00000000, 32'h00000000, 1'b0);
        acc(1'b0, `CREI_OFF_IEN, 32'h00000000, 32'h00000000, 1'b0);
        acc(1'b1, `CREI_OFF_IEN, 32'hFFFFFFFF, 32'h00000000, 1'b0);
        acc(1'b0, `CREI_OFF_IEN, 32'h00000000, 32'hFFFFFFFF, 1'b0);
        acc(1'b0, 12'h0FC, 32'h00000000, 32'h00000000, 1'b1);
        acc(1'b1, `CREI_OFF_EXCA, 32'h00000000, 32'h00000000, 1'b1);
        acc(1'b0, `CREI_OFF_EXCA, 32'h00000000, EXC_A, 1'b0);
        acc(1'b0, `CREI_OFF_VEC, 32'h00000000, `CREI_VEC_NONE, 1'b0);
    endtask

    task automatic t_irq;
        acc(1'b1, `CREI_OFF_IEN, 32'h00000028, 32'h00000000, 1'b0);
        src(32'h00000022, 32'h00000000);
        repeat (3) @(posedge pclk);
        flag("hw_irq", 1'b0);
        acc(1'b0, `CREI_OFF_PEND, 32'h00000000, 32'h00000020, 1'b0);
        acc(1'b1, `CREI_OFF_CTRL, 32'h00000001, 32'h00000000, 1'b0);
        repeat (2) @(posedge pclk);
        flag("hw_irq", 1'b1);
        src(32'h00000008, 32'h00000000);
        take(1'b0, 1'b1);
        acc(1'b0, `CREI_OFF_CTRL, 32'h00000000, 32'h00000002, 1'b0);
        acc(1'b0, `CREI_OFF_VEC, 32'h00000000, 32'h00000018, 1'b0);
        take(1'b0, 1'b0);
        acc(1'b1, `CREI_OFF_CTRL, 32'h00000001, 32'h00000000, 1'b0);
        repeat (2) @(posedge pclk);
        take(1'b0, 1'b1);
        src(32'h00000000, 32'hFFFFFFFF);
    endtask

    task automatic t_muldiv;
        take(1'b1, 1'b1);
        acc(1'b0, `CREI_OFF_STAT, 32'h00000000, 32'h00000010, 1'b0);
        take(1'b0, 1'b0);
    endtask

    task automatic t_local;
        int n;
        int f0;
        @(posedge pclk);
        debug_active <= 1'b1;
        reset_request <= 1'b1;
        pipe_empty <= 1'b0;
        repeat (8) @(posedge pclk);
        flag("in_reset", 1'b0);
        @(posedge pclk);
        debug_active <= 1'b0;
        repeat (4) @(posedge pclk);
        acc(1'b0, `CREI_OFF_STAT, 32'h00000000, 32'h00000012, 1'b0);
        flag("in_reset", 1'b0);
        @(posedge pclk);
        pipe_empty <= 1'b1;
        f0 = fetches;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (reset_taken !== 1'b1 && n < 10);
        check("in_reset", {31'h00000000, in_reset}, 32'h00000001);
        flag("reset_taken", 1'b0);
        n = 1;
        while (reset_taken !== 1'b1 && n < 40) begin
            @(negedge pclk);
            n++;
        end
        check("ack period", n, `CREI_ACK_CYC);
        repeat (20) @(posedge pclk);
        check("fetch seen", {31'h00000000, fetches > f0 + 1},
              32'h00000001);
        flag("in_reset", 1'b1);
        @(posedge pclk);
        reset_request <= 1'b0;
        repeat (3) @(posedge pclk);
        flag("in_reset", 1'b0);
    endtask

    task automatic t_global;
        @(posedge pclk);
        reset_request <= 1'b1;
        pipe_empty <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        flag("in_reset", 1'b1);
        @(posedge pclk);
        presetn <= 1'b1;
        reset_request <= 1'b0;
        pipe_empty <= 1'b1;
        repeat (4) @(posedge pclk);
        flag("in_reset", 1'b0);
    endtask

    // Every reset-address read must carry the configured address
    always @(negedge pclk) begin
        if (fetch_req === 1'b1) begin
            fetches++;
            check("fetch_addr", fetch_addr, RST_A);
        end
    end

    // Cuts a hang short well beyond the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            report_and_stop;
        end
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_regs;
        t_irq;
        t_muldiv;
        t_local;
        t_global;
        report_and_stop;
    end
endmodule
